// ### hw/swdt_map.vh
`ifndef SWDT_MAP_VH
`define SWDT_MAP_VH

// register byte offsets
`define SWDT_OFF_MODE     8'h00
`define SWDT_OFF_TIMEOUT  8'h04
`define SWDT_OFF_FEED     8'h08
`define SWDT_OFF_COUNT    8'h0C
`define SWDT_OFF_CLKSEL   8'h10
`define SWDT_OFF_STAT     8'h14
`define SWDT_OFF_MASK     8'h18

// mode register fields
`define SWDT_MODE_EN      0
`define SWDT_MODE_RESET   1

// status bits
`define SWDT_ST_TIMEOUT   0
`define SWDT_ST_BADFEED   1
`define SWDT_ST_RSTFLAG   2
`define SWDT_ST_W         3

// tick clock selection
`define SWDT_SEL_IRC      2'h0
`define SWDT_SEL_PCLK     2'h1
`define SWDT_SEL_RTC      2'h2

// feed sequence words
`define SWDT_FEED_A       8'hAA
`define SWDT_FEED_B       8'h55

// timing and reset values
`define SWDT_PRESCALE     2'h3
`define SWDT_MIN_TIMEOUT  32'h0000_00FF
`define SWDT_TIMEOUT_RST  32'h0000_00FF
`define SWDT_RST_PULSE    4'hF

// axi responses
`define SWDT_RESP_OKAY    2'h0
`define SWDT_RESP_SLVERR  2'h2

`endif

// ### hw/swdt_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "swdt_map.vh"

// picks a tick source, edge-detects it, divides by four
module swdt_tick (
  // clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // tick sources, synchronous levels
  input  wire       rtc_clk_in,
  input  wire       internal_rc_oscillator,
  input  wire       pclk_in,
  input  wire [1:0] sel,
  // prescaled tick enable
  output reg        tick_r
);

  reg       src_r;
  reg [1:0] pre_r;
  reg       src_nxt;

  always @* begin
    if (sel == `SWDT_SEL_RTC) begin
      src_nxt = rtc_clk_in;
    end else if (sel == `SWDT_SEL_PCLK) begin
      src_nxt = pclk_in;
    end else begin
      src_nxt = internal_rc_oscillator;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      src_r  <= 1'b0;
      pre_r  <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      src_r  <= src_nxt;
      tick_r <= 1'b0;
      if (src_nxt && !src_r) begin
        pre_r <= pre_r + 2'h1;
        // one tick per four source rising edges
        if (pre_r == `SWDT_PRESCALE) begin
          tick_r <= 1'b1;
        end
      end
    end
  end

endmodule // swdt_tick

`default_nettype wire

// ### hw/swdt_top.v
`timescale 1ns/1ps
`default_nettype none
`include "swdt_map.vh"

module swdt_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // tick sources
  input  wire        rtc_clk_in,
  input  wire        internal_rc_oscillator,
  input  wire        pclk_in,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // system outputs
  output reg         sys_reset_req_r,
  output reg         irq_r
);

  localparam ST_IDLE = 1'b0;
  localparam ST_HALF = 1'b1;

  // control and state
  reg        en_r;
  reg        rst_mode_r;
  reg [31:0] timeout_r;
  reg [31:0] count_r;
  reg [1:0]  sel_r;
  reg [2:0]  stat_r;
  reg [2:0]  mask_r;
  reg        feed_st_r;
  reg        wdt_flag_r;
  reg [3:0]  rst_cnt_r;
  // bus capture
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;

  wire       tick;
  wire       wr_go;
  wire       feed_wr;
  wire       feed_good;
  wire       feed_bad;
  wire       expire;
  wire       wdt_event;
  wire       self_rst;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  reg  [31:0] rd_nxt;
  reg         rd_err_nxt;
  reg         wr_err_nxt;
  reg  [2:0]  stat_nxt;

  // byte-lane merge, used by the timeout register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SWDT_OFF_MODE) || (a == `SWDT_OFF_TIMEOUT) ||
               (a == `SWDT_OFF_FEED) || (a == `SWDT_OFF_COUNT) ||
               (a == `SWDT_OFF_CLKSEL) || (a == `SWDT_OFF_STAT) ||
               (a == `SWDT_OFF_MASK);
    end
  endfunction

  swdt_tick u_tick (
    .ref_clk                (ref_clk),
    .sys_rst                (sys_rst),
    .rtc_clk_in             (rtc_clk_in),
    .internal_rc_oscillator (internal_rc_oscillator),
    .pclk_in                (pclk_in),
    .sel                    (sel_r),
    .tick_r                 (tick)
  );

  // write path: address and data may arrive in either order
  assign wa    = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wd    = w_held_r ? wdata_r : s_axi_wdata;
  assign ws    = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_go = (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid) &&
                 !s_axi_bvalid;

  // feed: 0xAA then 0x55, low byte lane only
  assign feed_wr   = wr_go && (wa == `SWDT_OFF_FEED) && ws[0];
  assign feed_good = feed_wr && (feed_st_r == ST_HALF) && (wd[7:0] == `SWDT_FEED_B);
  // while enabled, any other write in the middle of a sequence, or a stray second word, is an error
  assign feed_bad  = en_r && ((feed_wr && !feed_good && !(feed_st_r == ST_IDLE &&
                     wd[7:0] == `SWDT_FEED_A)) ||
                     (wr_go && (feed_st_r == ST_HALF) && !feed_wr));
  assign expire    = en_r && tick && (count_r == 32'h0000_0000);
  assign wdt_event = expire || feed_bad;
  // reset mode turns either event into a chip reset
  assign self_rst  = wdt_event && rst_mode_r;

  always @* begin
    stat_nxt = stat_r;
    if (wr_go && (wa == `SWDT_OFF_STAT) && ws[0]) begin
      stat_nxt = stat_r & ~wd[`SWDT_ST_W-1:0];
    end
    // set beats clear
    if (expire) begin
      stat_nxt[`SWDT_ST_TIMEOUT] = 1'b1;
    end
    if (feed_bad) begin
      stat_nxt[`SWDT_ST_BADFEED] = 1'b1;
    end
    stat_nxt[`SWDT_ST_RSTFLAG] = wdt_flag_r;
  end

  always @* begin
    wr_err_nxt = !mapped(wa) || (wa == `SWDT_OFF_COUNT);
  end

  always @* begin
    rd_nxt     = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    if (s_axi_araddr == `SWDT_OFF_MODE) begin
      rd_nxt = {30'h0, rst_mode_r, en_r};
    end else if (s_axi_araddr == `SWDT_OFF_TIMEOUT) begin
      rd_nxt = timeout_r;
    end else if (s_axi_araddr == `SWDT_OFF_FEED) begin
      rd_nxt = 32'h0000_0000;
    end else if (s_axi_araddr == `SWDT_OFF_COUNT) begin
      rd_nxt = count_r;
    end else if (s_axi_araddr == `SWDT_OFF_CLKSEL) begin
      rd_nxt = {30'h0, sel_r};
    end else if (s_axi_araddr == `SWDT_OFF_STAT) begin
      rd_nxt = {29'h0, stat_r};
    end else if (s_axi_araddr == `SWDT_OFF_MASK) begin
      rd_nxt = {29'h0, mask_r};
    end else begin
      rd_err_nxt = 1'b1;
    end
  end

  // axi handshakes
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SWDT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SWDT_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid && !aw_held_r && !s_axi_awready && !wr_go) begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_r && !s_axi_wready && !wr_go) begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        // taking a live channel this cycle acknowledges it
        s_axi_awready <= !aw_held_r;
        s_axi_wready  <= !w_held_r;
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_err_nxt ? `SWDT_RESP_SLVERR : `SWDT_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_nxt;
        s_axi_rresp   <= rd_err_nxt ? `SWDT_RESP_SLVERR : `SWDT_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // watchdog core
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      en_r       <= 1'b0;
      rst_mode_r <= 1'b0;
      timeout_r  <= `SWDT_TIMEOUT_RST;
      count_r    <= `SWDT_TIMEOUT_RST;
      sel_r      <= `SWDT_SEL_IRC;
      stat_r     <= 3'h0;
      mask_r     <= 3'h0;
      feed_st_r  <= ST_IDLE;
      rst_cnt_r  <= 4'h0;
      sys_reset_req_r <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
      if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
      end
      sys_reset_req_r <= self_rst || (rst_cnt_r > 4'h1);
      if (self_rst) begin
        rst_cnt_r <= `SWDT_RST_PULSE;
      end
      if (wr_go && (wa == `SWDT_OFF_MODE) && ws[0]) begin
        // enable is set-only
        en_r       <= en_r | wd[`SWDT_MODE_EN];
        rst_mode_r <= wd[`SWDT_MODE_RESET];
      end
      if (wr_go && (wa == `SWDT_OFF_TIMEOUT)) begin
        // below 256 ticks clamps to the floor
        if (merge(timeout_r, wd, ws) < `SWDT_MIN_TIMEOUT) begin
          timeout_r <= `SWDT_MIN_TIMEOUT;
        end else begin
          timeout_r <= merge(timeout_r, wd, ws);
        end
      end
      if (wr_go && (wa == `SWDT_OFF_CLKSEL) && ws[0]) begin
        if (wd[1:0] != 2'h3) begin
          sel_r <= wd[1:0];
        end
      end
      if (wr_go && (wa == `SWDT_OFF_MASK) && ws[0]) begin
        mask_r <= wd[`SWDT_ST_W-1:0];
      end
      if (feed_wr && (feed_st_r == ST_IDLE) && (wd[7:0] == `SWDT_FEED_A)) begin
        feed_st_r <= ST_HALF;
      end else if (wr_go) begin
        feed_st_r <= ST_IDLE;
      end
      // count of timeout+1 ticks gives 256..2^32 steps
      if (feed_good) begin
        count_r <= timeout_r;
      end else if (en_r && tick && count_r != 32'h0000_0000) begin
        count_r <= count_r - 32'h0000_0001;
      end else if (expire) begin
        count_r <= timeout_r;
      end
      // a watchdog event disarms the unit
      if (wdt_event) begin
        en_r <= 1'b0;
      end
    end
  end

  // flag survives the self reset; an outside sys_rst or a STAT write of bit 2 clears it
  always @(posedge ref_clk) begin
    if (sys_rst && rst_cnt_r == 4'h0) begin
      wdt_flag_r <= 1'b0;
    end else if (self_rst) begin
      wdt_flag_r <= 1'b1;
    end else if (wr_go && (wa == `SWDT_OFF_STAT) && ws[0] && wd[`SWDT_ST_RSTFLAG]) begin
      wdt_flag_r <= 1'b0;
    end
  end

endmodule // swdt_top

`default_nettype wire

// ### verif/swdt_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "swdt_map.vh"
module swdt_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // system outputs
  input wire logic        sys_reset_req_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wr_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not taken");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rd_take_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  rst_pulse_a: assert property ($rose(sys_reset_req_r) |-> sys_reset_req_r [*8])
    else $error("reset pulse short");
  rd_err_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid && s_axi_araddr > 8'h18
    |=> s_axi_rresp == `SWDT_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  tmo_floor_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    && s_axi_araddr == `SWDT_OFF_TIMEOUT |=> s_axi_rdata >= 32'hFF) else $error("timeout floor");
endmodule // swdt_chk
bind swdt_top swdt_chk i_swdt_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sys_reset_req_r(sys_reset_req_r));
`default_nettype wire

// ### verif/swdt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swdt_map.vh"
module swdt_top_tb;
  logic        ref_clk, rst_r, fb_en, saw_req, aw_v, w_v, b_r, ar_v, r_r;
  logic [2:0]  src_r;
  logic [7:0]  aw_a, ar_a;
  logic [31:0] w_d;
  wire logic   aw_rdy, w_rdy, b_v, ar_rdy, r_v, req, irq;
  wire logic [1:0]  b_rsp, r_rsp;
  wire logic [31:0] r_d;
  // watchdog pulse fed back as chip reset
  wire logic   rst_w = rst_r | (fb_en & req);
  integer      err_total, n_tests;
  swdt_top i_swdt_top (.ref_clk(ref_clk), .sys_rst(rst_w), .rtc_clk_in(src_r[2]),
    .internal_rc_oscillator(src_r[0]), .pclk_in(src_r[1]), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sys_reset_req_r(req), .irq_r(irq));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (req === 1'b1) saw_req <= 1'b1;
  task summarize;
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task hang;
    err_total++;
    $display("[ERR] %0t bus wait expired", $time);
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    int i;
    @(posedge ref_clk);
    aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (aw_rdy === 1'b1) aw_v <= 1'b0;
      if (w_rdy === 1'b1) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    if (i == 40) hang();
    b_r <= 1'b0;
    ck(b_rsp, e);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int i;
    @(posedge ref_clk);
    ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (ar_rdy === 1'b1) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    if (i == 40) hang();
    r_r <= 1'b0;
    ck(r_d & e, e);
    ck(r_d | e, e);
    ck(r_rsp, er);
  endtask
  task feed;
    wr(`SWDT_OFF_FEED, `SWDT_FEED_A);
    wr(`SWDT_OFF_FEED, `SWDT_FEED_B);
  endtask
  // rising edges of one source, four clocks each
  task automatic edges(input int s, input int n);
    repeat (n) begin
      @(posedge ref_clk) src_r[s] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      src_r[s] <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task ckirq(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 ck(irq, e);
  endtask
  task t_reset;
    rc(`SWDT_OFF_TIMEOUT, 32'hFF);
    rc(`SWDT_OFF_MODE, 32'h0);
    rc(`SWDT_OFF_STAT, 32'h0);
    rc(8'h1C, 32'h0, `SWDT_RESP_SLVERR);
    wr(`SWDT_OFF_COUNT, 32'h5, `SWDT_RESP_SLVERR);
  endtask
  task t_clamp;
    wr(`SWDT_OFF_TIMEOUT, 32'h10);
    rc(`SWDT_OFF_TIMEOUT, 32'hFF);
    wr(`SWDT_OFF_TIMEOUT, 32'h100);
    rc(`SWDT_OFF_TIMEOUT, 32'h100);
  endtask
  task t_enable;
    feed();
    rc(`SWDT_OFF_COUNT, 32'h100);
    wr(`SWDT_OFF_MODE, 32'h1);
    wr(`SWDT_OFF_MODE, 32'h0);
    rc(`SWDT_OFF_MODE, 32'h1);
  endtask
  task t_select;
    for (int s = 0; s < 3; s++) begin
      wr(`SWDT_OFF_CLKSEL, s);
      feed();
      edges((s + 1) % 3, 8);
      edges((s + 2) % 3, 8);
      rc(`SWDT_OFF_COUNT, 32'h100);
      edges(s, 8);
      rc(`SWDT_OFF_COUNT, 32'hFE);
    end
  endtask
  task t_expire;
    wr(`SWDT_OFF_TIMEOUT, 32'hFF);
    wr(`SWDT_OFF_MASK, 32'h1);
    feed();
    edges(2, 1020);
    rc(`SWDT_OFF_COUNT, 32'h0);
    ckirq(1'b0);
    edges(2, 4);
    ckirq(1'b1);
    rc(`SWDT_OFF_STAT, 32'h1);
    rc(`SWDT_OFF_MODE, 32'h0);
    rc(`SWDT_OFF_COUNT, 32'hFF);
    wr(`SWDT_OFF_MASK, 32'h0);
    ckirq(1'b0);
    wr(`SWDT_OFF_MASK, 32'h1);
    ckirq(1'b1);
    wr(`SWDT_OFF_STAT, 32'h1);
    ckirq(1'b0);
  endtask
  task t_badfeed;
    wr(`SWDT_OFF_MODE, 32'h1);
    wr(`SWDT_OFF_FEED, `SWDT_FEED_A);
    wr(`SWDT_OFF_TIMEOUT, 32'h100);
    rc(`SWDT_OFF_STAT, 32'h2);
    rc(`SWDT_OFF_MODE, 32'h0);
    wr(`SWDT_OFF_STAT, 32'h2);
    wr(`SWDT_OFF_FEED, `SWDT_FEED_B);
    rc(`SWDT_OFF_STAT, 32'h0);
    wr(`SWDT_OFF_MODE, 32'h1);
    wr(`SWDT_OFF_FEED, `SWDT_FEED_B);
    rc(`SWDT_OFF_STAT, 32'h2);
    wr(`SWDT_OFF_STAT, 32'h2);
  endtask
  task t_chiprst;
    wr(`SWDT_OFF_MODE, 32'h3);
    feed();
    fb_en <= 1'b1;
    edges(2, 1030);
    fb_en <= 1'b0;
    ck(saw_req, 1'b1);
    rc(`SWDT_OFF_STAT, 32'h4);
    @(posedge ref_clk) rst_r <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst_r <= 1'b0;
    rc(`SWDT_OFF_STAT, 32'h0);
  endtask
  initial begin
    {rst_r, fb_en, saw_req, aw_v, w_v, b_r, ar_v, r_r} = 8'h80;
    {src_r, aw_a, ar_a, w_d} = 51'h0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    rst_r <= 1'b0;
    t_reset();
    t_clamp();
    t_enable();
    t_select();
    t_expire();
    t_badfeed();
    t_chiprst();
    summarize();
  end
endmodule // swdt_top_tb
`default_nettype wire
